//--- rtl/half_bridge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "hb_cfg.svh"
// How it works
// - Reset: overcurrent enable high, outputs and clear bit low.
// - Three fixed command patterns enter internal test mode.
// - Filtered load supply undervoltage sets supply flag, disables outputs.
// - Outputs return at once when load supply recovers.
// - Supply flag stays until flag-clear written or sleep input goes low.
// - Filtered low current on an on switch sets sticky open-load flag.
// - Prewarning flag follows temperature, not sticky.
// - Prewarning bit is on serial out as soon as select falls.
// - Short frame aborts; command and status unchanged.
// - Thermal shutdown disables outputs, state bits read low.
// - After shutdown, outputs need cool and flag-clear.
// - Enabled overcurrent: filtered, switch off, set short flag.
// - Disabled overcurrent: short flag set, outputs untouched.
// - Flag-clear clears short flag, re-enables tripped outputs.
// - Sleep input low: outputs off, status cleared, standby.
// - Sleep release runs power-on reset of command register.
// - Command: bit0 flag-clear, bits1-6 switch controls.
// - Status: prewarn bit0, states 1-6, flags 13-15.
// - Flag-clear touches supply, open-load, short flags, trips and cooled thermal latch.
// - LSB first, sample on falling clock, execute on select rise.
module half_bridge_ctrl import hb_pkg::*; (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial link pins
	input wire logic link_clk,
	input wire logic frame_sel_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Control pin
	input wire logic sleep_control,
	// Analog sense inputs (asynchronous)
	input wire sense_s sense,
	// Switch drive
	output logic [5:0] switch_on,
	output logic switch_hiz,
	output logic standby,
	output logic test_mode
);
	// Whole core state
	typedef struct packed {
		core_state_e st;
		logic [5:0] cmd_out;
		logic overcurrent_shutdown_enable;
		logic tog_seen;
		logic tog_d;
		logic supply_flag;
		logic open_flag;
		logic short_flag;
		logic hot_latched;
		logic [5:0] tripped;
		logic [9:0] uv_cnt;
		logic [5:0][7:0] oc_cnt;
		logic [5:0][7:0] ol_cnt;
		logic test;
		logic [5:0] sw;
		logic hiz;
		logic stby;
		logic [15:0] status;
	} core_s;

	core_s q_ff, nxt_q;

	// Synchronised inputs
	logic sleep_s;
	sense_s sense_q;
	logic [15:0] rx_word, rx_word_s;
	logic rx_toggle, rx_toggle_s;
	logic [15:0] status_link;

	sync_2ff #(.W(1)) u_sync_sleep (
		.clk(core_clk),
		.rst(rst),
		.d(sleep_control),
		.q(sleep_s)
	);

	sync_2ff #(.W($bits(sense_s))) u_sync_sense (
		.clk(core_clk),
		.rst(rst),
		.d(sense),
		.q(sense_q)
	);

	// Word crosses as data held stable, qualified by a synchronised toggle
	sync_2ff #(.W(1)) u_sync_tog (
		.clk(core_clk),
		.rst(rst),
		.d(rx_toggle),
		.q(rx_toggle_s)
	);

	sync_2ff #(.W(16)) u_sync_word (
		.clk(core_clk),
		.rst(rst),
		.d(rx_word),
		.q(rx_word_s)
	);

	// Status toward link: held register, sampled by the link while frame open
	assign status_link = q_ff.status;

	serial_link u_link (
		.link_clk(link_clk),
		.rst(rst),
		.frame_sel_n(frame_sel_n),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe),
		.status_word(status_link),
		.rx_word(rx_word),
		.rx_toggle(rx_toggle)
	);

	// Test-mode pattern decode
	function automatic logic is_test(input logic [15:0] w);
		is_test = (w == `TEST_PAT_A) || (w == `TEST_PAT_B) || (w == `TEST_PAT_C);
	endfunction

	// Filter counter step: count while condition holds, saturate at limit
	function automatic logic [9:0] filt(input logic cond, input logic [9:0] c,
		input logic [9:0] lim);
		if (!cond) begin
			filt = '0;
		end else if (c < lim) begin
			filt = c + 10'd1;
		end else begin
			filt = c;
		end
	endfunction

	localparam logic [9:0] UV_LIM = 10'(`UV_FILTER_CYC);
	localparam logic [9:0] FF_LIM = 10'(`FAULT_FILTER_CYC);

	// Next-state logic
	always_comb begin
		logic new_word;
		logic clr;
		logic uv_now;
		logic [9:0] t;
		logic [5:0] ol_hit;
		logic [5:0] oc_hit;
		logic [5:0] eff;
		new_word = 1'b0;
		clr = 1'b0;
		uv_now = 1'b0;
		t = '0;
		ol_hit = '0;
		oc_hit = '0;
		eff = '0;
		nxt_q = q_ff;
		// Toggle delayed once more so the word bits settle first
		nxt_q.tog_d = rx_toggle_s;
		unique case (q_ff.st)
			ST_SLEEP: begin
				nxt_q.sw = '0;
				nxt_q.hiz = 1'b1;
				nxt_q.stby = 1'b1;
				nxt_q.status = '0;
				nxt_q.supply_flag = 1'b0;
				nxt_q.open_flag = 1'b0;
				nxt_q.short_flag = 1'b0;
				nxt_q.tripped = '0;
				nxt_q.hot_latched = 1'b0;
				nxt_q.tog_seen = rx_toggle_s;
				if (sleep_s) begin
					nxt_q.st = ST_POR;
				end
			end
			ST_POR: begin
				nxt_q.cmd_out = `CMD_RESET_OUTS;
				nxt_q.overcurrent_shutdown_enable = `CMD_RESET_OCS;
				nxt_q.test = 1'b0;
				nxt_q.hiz = 1'b0;
				nxt_q.stby = 1'b0;
				nxt_q.tog_seen = rx_toggle_s;
				nxt_q.st = sleep_s ? ST_RUN : ST_SLEEP;
			end
			ST_RUN: begin
				new_word = q_ff.tog_d != q_ff.tog_seen;
				nxt_q.tog_seen = q_ff.tog_d;
				if (new_word) begin
					// Unused command bits are not stored
					nxt_q.cmd_out = rx_word_s[`CMD_OUT_LSB +: 6];
					nxt_q.overcurrent_shutdown_enable = rx_word_s[`CMD_OCS_BIT];
					nxt_q.test = is_test(rx_word_s);
					clr = rx_word_s[`CMD_CLEAR_BIT];
				end
				// Undervoltage filter
				t = filt(sense_q.supply_low, q_ff.uv_cnt, UV_LIM);
				nxt_q.uv_cnt = t;
				uv_now = (t == UV_LIM);
				// Per-switch open-load and overcurrent filters
				for (int i = 0; i < 6; i++) begin
					t = filt(sense_q.open_load[i] && q_ff.sw[i], {2'b00, q_ff.ol_cnt[i]},
						FF_LIM);
					nxt_q.ol_cnt[i] = t[7:0];
					ol_hit[i] = (t == FF_LIM);
					t = filt(sense_q.over_current[i] && q_ff.sw[i], {2'b00, q_ff.oc_cnt[i]},
						FF_LIM);
					nxt_q.oc_cnt[i] = t[7:0];
					oc_hit[i] = (t == FF_LIM);
				end
				// Clears first so same-cycle events win
				if (clr) begin
					nxt_q.supply_flag = 1'b0;
					nxt_q.open_flag = 1'b0;
					nxt_q.short_flag = 1'b0;
					nxt_q.tripped = '0;
					if (!sense_q.shutdown_hot) begin
						nxt_q.hot_latched = 1'b0;
					end
				end
				if (uv_now) begin
					nxt_q.supply_flag = 1'b1;
				end
				if (|ol_hit) begin
					nxt_q.open_flag = 1'b1;
				end
				if (|oc_hit) begin
					nxt_q.short_flag = 1'b1;
					if (nxt_q.overcurrent_shutdown_enable) begin
						nxt_q.tripped = nxt_q.tripped | oc_hit;
					end
				end
				if (sense_q.shutdown_hot) begin
					nxt_q.hot_latched = 1'b1;
				end
				// Actual switch state after all protection
				eff = nxt_q.cmd_out & ~nxt_q.tripped;
				if (uv_now || nxt_q.hot_latched) begin
					eff = '0;
				end
				nxt_q.sw = eff;
				nxt_q.status = '0;
				nxt_q.status[`STAT_PREWARN_BIT] = sense_q.prewarn_hot;
				nxt_q.status[`CMD_OUT_LSB +: 6] = eff;
				nxt_q.status[`STAT_SHORT_BIT] = nxt_q.short_flag;
				nxt_q.status[`STAT_OPEN_BIT] = nxt_q.open_flag;
				nxt_q.status[`STAT_SUPPLY_BIT] = nxt_q.supply_flag;
				// Sleep pin low: outputs off at once, not a cycle later
				if (!sleep_s) begin
					nxt_q.st = ST_SLEEP;
					nxt_q.sw = '0;
					nxt_q.hiz = 1'b1;
					nxt_q.stby = 1'b1;
					nxt_q.status = '0;
				end
			end
			default: begin
				nxt_q.st = ST_SLEEP;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q_ff <= '{st: ST_SLEEP, hiz: 1'b1, stby: 1'b1, overcurrent_shutdown_enable: `CMD_RESET_OCS,
				default: '0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Outputs straight from state flops
	assign switch_on = q_ff.sw;
	assign switch_hiz = q_ff.hiz;
	assign standby = q_ff.stby;
	assign test_mode = q_ff.test;

	// Checks
	sequence hot_seen_s;
		sense_q.shutdown_hot && q_ff.st == ST_RUN && sleep_s;
	endsequence

	sequence clr_word_s;
		q_ff.st == ST_RUN && q_ff.tog_d != q_ff.tog_seen && rx_word_s[0];
	endsequence

	por_state_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.st == ST_POR |=> q_ff.overcurrent_shutdown_enable && q_ff.cmd_out == 6'h00)
		else $error("command not at reset value after power-on");

	test_mode_a: assert property (@(posedge core_clk) disable iff (rst)
		(q_ff.st == ST_RUN && q_ff.tog_d != q_ff.tog_seen && sleep_s)
		|=> test_mode == is_test($past(rx_word_s)))
		else $error("test mode decode wrong");

	supply_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.supply_flag && q_ff.st == ST_RUN && sleep_s
		&& !(q_ff.tog_d != q_ff.tog_seen && rx_word_s[0])
		|=> q_ff.supply_flag)
		else $error("supply flag dropped without clear");

	short_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		clr_word_s ##0 (sense_q.over_current == 6'h00)
		|=> !q_ff.short_flag && q_ff.tripped == 6'h00)
		else $error("short flag or trip kept after clear");

	hot_off_a: assert property (@(posedge core_clk) disable iff (rst)
		hot_seen_s |=> (switch_on == 6'h00 && q_ff.status[6:1] == 6'h00)
		##1 (!q_ff.hot_latched || q_ff.status[6:1] == 6'h00))
		else $error("outputs on during thermal shutdown");

	uv_off_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.st == ST_RUN && sleep_s && q_ff.uv_cnt == UV_LIM - 10'd1 && sense_q.supply_low
		|=> switch_on == 6'h00 && q_ff.supply_flag)
		else $error("undervoltage did not disable outputs");

	prewarn_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.st == ST_RUN && sleep_s |=> q_ff.status[0] == $past(sense_q.prewarn_hot))
		else $error("prewarning bit does not follow sense");

	sleep_off_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.st == ST_SLEEP |-> switch_on == 6'h00 && switch_hiz && q_ff.status == 16'h0000)
		else $error("sleep state not quiet");

	unused_low_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.status[12:7] == 6'h00)
		else $error("unused status bits not low");

	state_match_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.st == ST_RUN |-> q_ff.status[6:1] == switch_on)
		else $error("status states differ from switches");

	short_set_a: assert property (@(posedge core_clk) disable iff (rst)
		q_ff.st == ST_RUN && sleep_s && (q_ff.oc_cnt[0] == 8'(FF_LIM - 10'd1))
		&& sense_q.over_current[0] && q_ff.sw[0] |=> q_ff.short_flag)
		else $error("short flag not set after filter");
endmodule
`default_nettype wire

//--- include/hb_cfg.svh
`ifndef HB_CFG_SVH
`define HB_CFG_SVH

// Command word fields
`define CMD_CLEAR_BIT 0
`define CMD_OUT_LSB 1
`define CMD_OCS_BIT 13
`define CMD_RESET_OCS 1'b1
`define CMD_RESET_OUTS 6'h00

// Test-mode command patterns
`define TEST_PAT_A 16'hF800
`define TEST_PAT_B 16'hE600
`define TEST_PAT_C 16'hE180

// Status word fields
`define STAT_PREWARN_BIT 0
`define STAT_SHORT_BIT 13
`define STAT_OPEN_BIT 14
`define STAT_SUPPLY_BIT 15

// Filter delays in ns and derived core cycles (50 MHz, 20 ns period)
`define CORE_PERIOD_NS 20
`define UV_FILTER_NS 10000
`define FAULT_FILTER_NS 4000
`define UV_FILTER_CYC ((`UV_FILTER_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define FAULT_FILTER_CYC ((`FAULT_FILTER_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

`endif

//--- include/hb_pkg.sv
package hb_pkg;
	// Command word as delivered by the link
	typedef struct packed {
		logic [15:0] word;
	} cmd_word_s;

	// Analog fault sense inputs, one bit per switch where relevant
	typedef struct packed {
		logic supply_low;
		logic prewarn_hot;
		logic shutdown_hot;
		logic [5:0] open_load;
		logic [5:0] over_current;
	} sense_s;

	// Core state machine
	typedef enum logic [2:0] {
		ST_SLEEP = 3'b001,
		ST_POR = 3'b010,
		ST_RUN = 3'b100
	} core_state_e;
endpackage

//--- rtl/sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// Two-flop level synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule
`default_nettype wire

//--- rtl/serial_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "hb_cfg.svh"
module serial_link import hb_pkg::*; (
	// Link pins
	input wire logic link_clk,
	input wire logic rst,
	input wire logic frame_sel_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Status snapshot from core (quasi-static while frame open)
	input wire logic [15:0] status_word,
	// Completed word, toggle marks each new word
	output logic [15:0] rx_word,
	output logic rx_toggle
);
	typedef struct packed {
		logic [15:0] shin;
		logic [4:0] cnt;
		logic seen;
	} fall_s;

	fall_s s_ff, nxt_s;
	logic frame_tog_ff;
	logic [4:0] ocnt_ff;

	// Falling edge: sample input bits LSB first
	always_comb begin
		nxt_s = s_ff;
		if (!frame_sel_n) begin
			if (s_ff.seen != frame_tog_ff) begin
				// First bit of a new frame restarts the count
				nxt_s.shin = {serial_in, s_ff.shin[15:1]};
				nxt_s.cnt = 5'd1;
				nxt_s.seen = frame_tog_ff;
			end else if (s_ff.cnt < 5'd16) begin
				nxt_s.shin = {serial_in, s_ff.shin[15:1]};
				nxt_s.cnt = s_ff.cnt + 5'd1;
			end
		end
	end

	always_ff @(negedge link_clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Frame end: execute only a full word of this frame, else abort
	always_ff @(posedge frame_sel_n or posedge rst) begin
		if (rst) begin
			rx_word <= '0;
			rx_toggle <= 1'b0;
			frame_tog_ff <= 1'b0;
		end else begin
			// Closes the frame so the next first bit restarts the count
			frame_tog_ff <= ~frame_tog_ff;
			if (s_ff.cnt == 5'd16 && s_ff.seen == frame_tog_ff) begin
				rx_word <= s_ff.shin;
				rx_toggle <= ~rx_toggle;
			end
		end
	end

	// Output bit counter, held clear while select is high
	// Bit 0 appears at select fall, next bit on each rising clock
	always_ff @(posedge link_clk or posedge frame_sel_n) begin
		if (frame_sel_n) begin
			ocnt_ff <= '0;
		end else if (ocnt_ff < 5'd16) begin
			ocnt_ff <= ocnt_ff + 5'd1;
		end
	end

	always_comb begin
		serial_out = (ocnt_ff < 5'd16) ? status_word[ocnt_ff[3:0]] : 1'b0;
		serial_out_oe = !frame_sel_n;
	end
endmodule
`default_nettype wire

//--- tb/host_link.sv
`timescale 1ns/1ps
`default_nettype none
module host_link (
	// Link pins
	output logic link_clk,
	output logic frame_sel_n,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	// Idle link: clock still, select high
	initial begin
		link_clk = 1'b0;
		frame_sel_n = 1'b1;
		serial_in = 1'b0;
	end

	// One frame of n bits, bit 0 first, status read before each rise
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		frame_sel_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#3;
			rx[i] = serial_out_oe ? serial_out : 1'bx;
			link_clk = 1'b1;
			// Data moves on the rise, half a period before the falling sample
			serial_in = tx[i];
			#3;
			link_clk = 1'b0;
		end
		#3;
		frame_sel_n = 1'b1;
		// Released line shows no stale value
		serial_in = ~serial_in;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_half_bridge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "hb_cfg.svh"
module tb_half_bridge_ctrl import hb_pkg::*;;
	logic core_clk, rst, link_clk, frame_sel_n, serial_in, serial_out, serial_out_oe;
	logic sleep_control, switch_hiz, standby, test_mode;
	logic [5:0] switch_on;
	logic [15:0] r;
	logic [15:0] pats [3] = '{`TEST_PAT_A, `TEST_PAT_B, `TEST_PAT_C};
	sense_s sense;
	int num_errors = 0;
	int compares = 0;

	half_bridge_ctrl dut (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
		.frame_sel_n(frame_sel_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .sleep_control(sleep_control), .sense(sense),
		.switch_on(switch_on), .switch_hiz(switch_hiz), .standby(standby),
		.test_mode(test_mode));

	host_link host (.link_clk(link_clk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));

	// Core clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic sw(input logic [5:0] e);
		check("switch_on", 16'(switch_on), 16'(e));
	endtask

	// Full word, then compare the status shifted out
	task automatic rd(input logic [15:0] w, input logic [15:0] exp);
		logic [15:0] x;
		host.xfer(w, 16, x);
		check("status", x, exp);
		cyc(8);
	endtask

	task automatic wr(input logic [15:0] w);
		logic [15:0] x;
		host.xfer(w, 16, x);
		cyc(8);
	endtask

	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		rst = 1'b1;
		sleep_control = 1'b1;
		sense = '0;
		cyc(2);
		rst = 1'b0;
		cyc(10);
		sw(6'h00);
		check("standby", 16'(standby), 16'h0000);
		rd(16'h2000, 16'h0000);
		$display("test reset done");
		wr(16'hFFFE);
		sw(6'h3F);
		check("test_mode", 16'(test_mode), 16'h0000);
		rd(16'h207E, 16'h007E);
		for (int i = 0; i < 3; i++) begin
			wr(pats[i]);
			check("test_mode", 16'(test_mode), 16'h0001);
		end
		wr(16'h2006);
		check("test_mode", 16'(test_mode), 16'h0000);
		$display("test command done");
		host.xfer(16'h207E, 8, r);
		cyc(8);
		sw(6'h03);
		sense.prewarn_hot = 1'b1;
		cyc(4);
		host.xfer(16'h0000, 1, r);
		check("prewarn", r, 16'h0001);
		cyc(8);
		sw(6'h03);
		rd(16'h2006, 16'h0007);
		sense.prewarn_hot = 1'b0;
		cyc(4);
		rd(16'h207E, 16'h0006);
		$display("test frame done");
		sense.over_current = 6'h04;
		cyc(260);
		sw(6'h3B);
		sense.over_current = 6'h00;
		rd(16'h207E, 16'h2076);
		wr(16'h207F);
		sw(6'h3F);
		rd(16'h007E, 16'h007E);
		sense.over_current = 6'h01;
		cyc(260);
		sw(6'h3F);
		sense.over_current = 6'h00;
		rd(16'h207F, 16'h207E);
		$display("test short done");
		sense.supply_low = 1'b1;
		cyc(560);
		sw(6'h00);
		sense.supply_low = 1'b0;
		cyc(6);
		sw(6'h3F);
		rd(16'h207E, 16'h807E);
		rd(16'h207F, 16'h807E);
		rd(16'h207E, 16'h007E);
		sense.open_load = 6'h02;
		cyc(260);
		sense.open_load = 6'h00;
		cyc(4);
		rd(16'h207E, 16'h407E);
		rd(16'h207F, 16'h407E);
		rd(16'h207E, 16'h007E);
		$display("test flags done");
		sense.shutdown_hot = 1'b1;
		cyc(6);
		sw(6'h00);
		sense.shutdown_hot = 1'b0;
		cyc(6);
		sw(6'h00);
		rd(16'h207F, 16'h0000);
		sw(6'h3F);
		$display("test thermal done");
		sleep_control = 1'b0;
		cyc(6);
		sw(6'h00);
		check("hiz", 16'(switch_hiz), 16'h0001);
		check("standby", 16'(standby), 16'h0001);
		sleep_control = 1'b1;
		cyc(10);
		sw(6'h00);
		check("standby", 16'(standby), 16'h0000);
		rd(16'h207E, 16'h0000);
		sw(6'h3F);
		$display("test sleep done");
		report_and_stop();
	end
endmodule
`default_nettype wire
